// ==== sim/jfl_host_model.sv ====
// host model: debug probe driving the test port
`timescale 1ns/1ns
module jfl_host_model (
    // clock
    input wire logic core_clock_freq,
    // test port
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end
    // one test clock, five system clocks low and four high; tck stands low between frames
    task automatic step(input logic m, input logic d, output logic q);
        @(posedge core_clock_freq) #1;
        tms = m;
        tdi = d;
        repeat (4) @(posedge core_clock_freq);
        q = tdo;
        #1 tck = 1'b1;
        repeat (4) @(posedge core_clock_freq);
        #1 tck = 1'b0;
        tdi = ~d;
    endtask : step
    // instruction or data scan from idle, back to idle through update
    task automatic scan(input logic ir, input logic [6:0] v, input int n, output logic [6:0] c);
        logic q;
        step(1'b1, 1'b0, q);
        if (ir) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, v[i], q);
            c[i] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask : scan
    task automatic reset_tap();
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask : reset_tap
    task automatic pulse_trst();
        @(posedge core_clock_freq) #1;
        trst_n = 1'b0;
        repeat (4) @(posedge core_clock_freq);
        #1 trst_n = 1'b1;
    endtask : pulse_trst
endmodule : jfl_host_model

// ==== sim/jfl_monitor.sv ====
// checker: port assertions for the lockout recovery block
`timescale 1ns/1ns
module jfl_monitor (
    // clock and resets
    input wire logic core_clock_freq,
    input wire logic rst_n,
    input wire logic trst_n,
    // flash side inputs
    input wire logic security_secure,
    input wire logic backdoor_key_enable,
    input wire logic backdoor_key_match,
    // outputs watched
    input wire jfl_pkg::jfl_div_t erase_clock_divider_field,
    input wire logic flash_timing_tick,
    input wire logic mass_erase_busy,
    input wire logic erase_complete,
    input wire logic debug_read_disable,
    input wire logic backdoor_unlock
);
    import jfl_pkg::*;
    logic [10:0] gap_r;
    logic [1:0] arm_r;
    logic [10:0] exp_gap;
    jfl_div_t div_r;
    assign exp_gap = (erase_clock_divider_field.prescale_by_eight ? 11'h010 : 11'h002)
        * (11'(erase_clock_divider_field.divisor) + 11'h001);
    // period is only judged after two ticks under a steady divider
    always_ff @(posedge core_clock_freq) begin
        div_r <= erase_clock_divider_field;
        gap_r <= flash_timing_tick ? 11'h001 : gap_r + 11'h001;
        if (!rst_n || div_r != erase_clock_divider_field) arm_r <= 2'h0;
        else if (flash_timing_tick && arm_r != 2'h2) arm_r <= arm_r + 2'h1;
    end
    default clocking cb @(posedge core_clock_freq); endclocking
    default disable iff (!rst_n);
    sequence s_trst_held;
        !trst_n [*3];
    endsequence
    sequence s_done;
        $fell(mass_erase_busy) ##0 erase_complete;
    endsequence
    AST_RST_VAL: assert property (disable iff (1'b0) !rst_n |=> debug_read_disable
        && !erase_complete && !mass_erase_busy && !backdoor_unlock) else $error("reset values");
    AST_RDIS_LOAD: assert property ($rose(rst_n) |=>
        debug_read_disable == $past(security_secure)) else $error("read disable load");
    AST_RDIS_HOLD: assert property (rst_n && $past(rst_n) |=>
        $stable(debug_read_disable)) else $error("read disable moved");
    AST_BACKDOOR: assert property (rst_n && $past(rst_n) |-> backdoor_unlock ==
        ($past(backdoor_key_enable) && $past(backdoor_key_match))) else $error("backdoor");
    AST_DONE: assert property ($rose(erase_complete) |-> s_done) else $error("done");
    AST_STICKY: assert property (erase_complete |=> erase_complete) else $error("sticky");
    AST_ABORT: assert property (s_trst_held |-> !mass_erase_busy) else $error("abort");
    AST_EXCL: assert property (erase_complete |-> !mass_erase_busy) else $error("excl");
    AST_PULSE: assert property (flash_timing_tick |=> !flash_timing_tick) else $error("pulse");
    AST_GAP: assert property (flash_timing_tick && arm_r == 2'h2 |-> gap_r == exp_gap)
        else $error("tick period");
endmodule : jfl_monitor

bind jfl_lockout_recovery jfl_monitor u_mon (.core_clock_freq(core_clock_freq), .rst_n(rst_n),
    .trst_n(trst_n), .security_secure(security_secure),
    .backdoor_key_enable(backdoor_key_enable), .backdoor_key_match(backdoor_key_match),
    .erase_clock_divider_field(erase_clock_divider_field),
    .flash_timing_tick(flash_timing_tick), .mass_erase_busy(mass_erase_busy),
    .erase_complete(erase_complete), .debug_read_disable(debug_read_disable),
    .backdoor_unlock(backdoor_unlock));

// ==== sim/tb_jfl_lockout_recovery.sv ====
// testbench: unlock flow, divider override, erase and reset behaviour
`timescale 1ns/1ns
module tb_jfl_lockout_recovery;
    import jfl_pkg::*;
    localparam int ETICKS = 8;
    logic core_clock_freq = 1'b0, rst_n = 1'b0, sec = 1'b1, ken = 1'b0, kmatch = 1'b0;
    logic tck, tms, tdi, trst_n, tdo, tdo_oe_n, erase_tick, busy, done, rdis, bd;
    jfl_div_t flash_div = 7'h00, field;
    int err_count = 0, compares = 0, cycles = 0;
    logic [9:0] q [$];
    logic [9:0] nt;
    int oe_cnt = 0;
    // counts cycles with the test data output driven
    always @(posedge core_clock_freq) if (tdo_oe_n === 1'b0) oe_cnt++;
    always #20 core_clock_freq = ~core_clock_freq;
    jfl_host_model host (.core_clock_freq(core_clock_freq), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo(tdo));
    jfl_lockout_recovery #(.ERASE_TICKS(ETICKS)) dut (.core_clock_freq(core_clock_freq), .rst_n(rst_n),
        .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
        .flash_clock_divider_reg(flash_div), .security_secure(sec),
        .backdoor_key_enable(ken), .backdoor_key_match(kmatch),
        .erase_clock_divider_field(field), .flash_timing_tick(erase_tick),
        .mass_erase_busy(busy), .erase_complete(done), .debug_read_disable(rdis),
        .backdoor_unlock(bd));
    task automatic check(input string nm, input logic [6:0] seen, input logic [6:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    // expectation becomes due at the next clock edge
    task automatic note(input logic [2:0] k, input logic [6:0] e);
        @(posedge core_clock_freq) #1;
        q.push_back({k, e});
    endtask : note
    always @(posedge core_clock_freq) begin
        #2;
        while (q.size() > 0) begin
            nt = q.pop_front();
            case (nt[9:7])
                3'h0: check("divider", field, nt[6:0]);
                3'h1: check("complete", 7'(done), nt[6:0]);
                3'h2: check("backdoor", 7'(bd), nt[6:0]);
                3'h3: check("read_disable", 7'(rdis), nt[6:0]);
                3'h5: check("tdo_oe_n", 7'(tdo_oe_n), nt[6:0]);
                default: check("busy", 7'(busy), nt[6:0]);
            endcase
        end
    end
    always @(posedge core_clock_freq) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic do_reset();
        @(posedge core_clock_freq) #1;
        rst_n = 1'b0;
        flash_div = 7'($urandom);
        sec = 1'($urandom);
        repeat (20) @(posedge core_clock_freq);
        #1 rst_n = 1'b1;
        note(3'h3, 7'(sec));
        note(3'h0, flash_div);
        host.reset_tap();
    endtask : do_reset
    initial begin
        logic [6:0] c;
        logic [6:0] d;
        int n0;
        c = 7'($urandom(32'hd903_cf68));
        for (int it = 0; it < 3; it++) begin
            do_reset();
            for (int k = 0; k < 4; k++) begin
                {kmatch, ken} = 2'(k);
                note(3'h2, 7'(ken & kmatch));
            end
            host.scan(1'b1, 7'(JFL_INS_UNLOCK_DEF), 4, c);
            check("ir_capture", 7'(c[3:0]), 7'(JFL_IR_CAPTURE));
            note(3'h4, 7'h00);
            note(3'h0, JFL_DIV_RST);
            note(3'h5, 7'h01);
            n0 = oe_cnt;
            d = it[0] ? {1'b1, 6'(7 + $urandom_range(2))} : {1'b0, 6'(62 + $urandom_range(1))};
            host.scan(1'b0, d, 7, c);
            check("dr_capture", c, JFL_DIV_RST);
            check("tdo_driven", 7'(oe_cnt != n0), 7'h01);
            note(3'h0, d);
            note(3'h4, 7'h01);
            for (int w = 0; w < 2000 && !done && it < 2; w++) @(posedge core_clock_freq) #1;
            host.pulse_trst();
            note(3'h1, 7'(it < 2));
            note(3'h4, 7'h00);
            note(3'h0, flash_div);
            host.reset_tap();
        end
        repeat (3) @(posedge core_clock_freq);
        print_verdict();
    end
endmodule : tb_jfl_lockout_recovery

// ==== verilog/jfl_lockout_recovery.sv ====
// module: test-port lockout recovery with flash erase clock divider override
// Function
// - unlock sequence mass-erases flash; debug read disable holds until the next reset
// - unlock instruction selects 7-bit divider register
// - shifted divider replaces flash divider register
// - bit6 prescale, bits5-0 divisor
// - input clock/2, optional /8, /(div+1)
// - entering Run-Test/Idle under the unlock instruction with a loaded divider starts the erase
// - backdoor unlock only when key enable set
// - reset sets debug read disable; the first clock after reset release loads it from security
`timescale 1ns/1ns
module jfl_lockout_recovery #(
    parameter logic [jfl_pkg::JFL_IR_W-1:0] INS_UNLOCK = jfl_pkg::JFL_INS_UNLOCK_DEF,
    parameter int ERASE_TICKS = jfl_pkg::JFL_ERASE_TICKS_DEF
) (
    // clock and reset
    input wire logic core_clock_freq,
    input wire logic rst_n,
    // test port
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    output logic tdo,
    output logic tdo_oe_n,
    // flash module side
    input wire jfl_pkg::jfl_div_t flash_clock_divider_reg,
    input wire logic security_secure,
    input wire logic backdoor_key_enable,
    input wire logic backdoor_key_match,
    output jfl_pkg::jfl_div_t erase_clock_divider_field,
    output logic flash_timing_tick,
    output logic mass_erase_busy,
    output logic erase_complete,
    output logic debug_read_disable,
    output logic backdoor_unlock
);
    import jfl_pkg::*;

    localparam logic [JFL_ERASE_CNT_W-1:0] ERASE_LAST = JFL_ERASE_CNT_W'(ERASE_TICKS - 1);

    jfl_state_t s_r;
    jfl_state_t s_nxt;

    function automatic jfl_tap_t tap_next(input jfl_tap_t st, input logic m);
        case (st)
            JFL_TAP_RESET: tap_next = m ? JFL_TAP_RESET : JFL_TAP_IDLE;
            JFL_TAP_IDLE: tap_next = m ? JFL_TAP_SEL_DR : JFL_TAP_IDLE;
            JFL_TAP_SEL_DR: tap_next = m ? JFL_TAP_SEL_IR : JFL_TAP_CAP_DR;
            JFL_TAP_CAP_DR: tap_next = m ? JFL_TAP_EX1_DR : JFL_TAP_SH_DR;
            JFL_TAP_SH_DR: tap_next = m ? JFL_TAP_EX1_DR : JFL_TAP_SH_DR;
            JFL_TAP_EX1_DR: tap_next = m ? JFL_TAP_UPD_DR : JFL_TAP_PA_DR;
            JFL_TAP_PA_DR: tap_next = m ? JFL_TAP_EX2_DR : JFL_TAP_PA_DR;
            JFL_TAP_EX2_DR: tap_next = m ? JFL_TAP_UPD_DR : JFL_TAP_SH_DR;
            JFL_TAP_UPD_DR: tap_next = m ? JFL_TAP_SEL_DR : JFL_TAP_IDLE;
            JFL_TAP_SEL_IR: tap_next = m ? JFL_TAP_RESET : JFL_TAP_CAP_IR;
            JFL_TAP_CAP_IR: tap_next = m ? JFL_TAP_EX1_IR : JFL_TAP_SH_IR;
            JFL_TAP_SH_IR: tap_next = m ? JFL_TAP_EX1_IR : JFL_TAP_SH_IR;
            JFL_TAP_EX1_IR: tap_next = m ? JFL_TAP_UPD_IR : JFL_TAP_PA_IR;
            JFL_TAP_PA_IR: tap_next = m ? JFL_TAP_EX2_IR : JFL_TAP_PA_IR;
            JFL_TAP_EX2_IR: tap_next = m ? JFL_TAP_UPD_IR : JFL_TAP_SH_IR;
            JFL_TAP_UPD_IR: tap_next = m ? JFL_TAP_SEL_DR : JFL_TAP_IDLE;
            default: tap_next = JFL_TAP_RESET;
        endcase
    endfunction : tap_next

    localparam jfl_state_t S_RST = '{
        tap: JFL_TAP_RESET,
        tck_q: 1'b0,
        ir: JFL_INS_BYPASS,
        ir_sh: JFL_INS_BYPASS,
        dr_sh: 7'h00,
        byp: 1'b0,
        jtag_div: JFL_DIV_RST,
        div_loaded: 1'b0,
        tdo: 1'b0,
        tdo_oe_n: 1'b1,
        eff_div: JFL_DIV_RST,
        pre_cnt: 4'h0,
        div_cnt: 6'h00,
        tick: 1'b0,
        busy: 1'b0,
        done: 1'b0,
        erase_cnt: 16'h0000,
        cap_pending: 1'b1,
        read_disable: 1'b1,
        backdoor: 1'b0
    };

    logic tck_rise;
    logic tck_fall;
    logic unlock_sel;
    jfl_tap_t tap_nx;
    jfl_div_t div_use;
    logic [JFL_PRE_CNT_W-1:0] pre_lim;

    always_comb begin
        s_nxt = s_r;
        tck_rise = tck & ~s_r.tck_q;
        tck_fall = ~tck & s_r.tck_q;
        unlock_sel = (s_r.ir == INS_UNLOCK);
        tap_nx = tap_next(s_r.tap, tms);
        s_nxt.tck_q = tck;
        s_nxt.tick = 1'b0;

        if (!trst_n) begin
            s_nxt.tap = JFL_TAP_RESET;
            s_nxt.ir = JFL_INS_BYPASS;
        end else if (tck_rise) begin
            case (s_r.tap)
                JFL_TAP_CAP_IR: s_nxt.ir_sh = JFL_IR_CAPTURE;
                JFL_TAP_SH_IR: s_nxt.ir_sh = {tdi, s_r.ir_sh[JFL_IR_W-1:1]};
                JFL_TAP_UPD_IR: s_nxt.ir = s_r.ir_sh;
                JFL_TAP_CAP_DR: begin
                    s_nxt.dr_sh = s_r.jtag_div;
                    s_nxt.byp = 1'b0;
                end
                JFL_TAP_SH_DR: begin
                    if (unlock_sel) begin
                        s_nxt.dr_sh = {tdi, s_r.dr_sh[JFL_DIV_W-1:1]};
                    end else begin
                        s_nxt.byp = tdi;
                    end
                end
                JFL_TAP_UPD_DR: begin
                    if (unlock_sel) begin
                        s_nxt.jtag_div = s_r.dr_sh;
                        s_nxt.div_loaded = 1'b1;
                    end
                end
                default: begin
                end
            endcase
            s_nxt.tap = tap_nx;
            // erase starts on entry to idle under the unlock instruction with a loaded divider
            // a divider update on this same edge counts as loaded
            if (tap_nx == JFL_TAP_IDLE && s_r.tap != JFL_TAP_IDLE && unlock_sel &&
                s_nxt.div_loaded && !s_r.busy && !s_r.done) begin
                s_nxt.busy = 1'b1;
                s_nxt.erase_cnt = '0;
            end
        end

        if (tck_fall) begin
            s_nxt.tdo_oe_n = !(s_r.tap == JFL_TAP_SH_IR || s_r.tap == JFL_TAP_SH_DR);
            if (s_r.tap == JFL_TAP_SH_IR) begin
                s_nxt.tdo = s_r.ir_sh[0];
            end else if (unlock_sel) begin
                s_nxt.tdo = s_r.dr_sh[0];
            end else begin
                s_nxt.tdo = s_r.byp;
            end
        end

        // override only while the unlock instruction is current
        div_use = unlock_sel ? s_r.jtag_div : flash_clock_divider_reg;
        s_nxt.eff_div = div_use;
        pre_lim = s_r.eff_div.prescale_by_eight ? JFL_PRE_LIM_DIV8 : JFL_PRE_LIM_PLAIN;
        if (s_r.pre_cnt >= pre_lim) begin
            s_nxt.pre_cnt = '0;
            if (s_r.div_cnt >= s_r.eff_div.divisor) begin
                s_nxt.div_cnt = '0;
                s_nxt.tick = 1'b1;
            end else begin
                s_nxt.div_cnt = s_r.div_cnt + 6'h01;
            end
        end else begin
            s_nxt.pre_cnt = s_r.pre_cnt + 4'h1;
        end

        // erase timed in flash clock ticks; leaving idle aborts it
        if (s_r.busy) begin
            if (!trst_n || s_r.tap != JFL_TAP_IDLE) begin
                s_nxt.busy = 1'b0;
            end else if (s_r.tick) begin
                if (s_r.erase_cnt == ERASE_LAST) begin
                    s_nxt.busy = 1'b0;
                    s_nxt.done = 1'b1;
                end else begin
                    s_nxt.erase_cnt = s_r.erase_cnt + 16'h0001;
                end
            end
        end

        // security level caught once after reset release
        if (s_r.cap_pending) begin
            s_nxt.cap_pending = 1'b0;
            s_nxt.read_disable = security_secure;
        end else if (s_r.done) begin
            s_nxt.read_disable = s_r.read_disable;
        end
        s_nxt.backdoor = backdoor_key_enable & backdoor_key_match;
    end

    always_ff @(posedge core_clock_freq) begin
        if (!rst_n) begin
            s_r <= S_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tdo = s_r.tdo;
    assign tdo_oe_n = s_r.tdo_oe_n;
    assign erase_clock_divider_field = s_r.eff_div;
    assign flash_timing_tick = s_r.tick;
    assign mass_erase_busy = s_r.busy;
    assign erase_complete = s_r.done;
    assign debug_read_disable = s_r.read_disable;
    assign backdoor_unlock = s_r.backdoor;
endmodule : jfl_lockout_recovery

// ==== verilog/jfl_pkg.sv ====
// package: constants and types for the flash lockout recovery test port
package jfl_pkg;
    localparam int JFL_IR_W = 4;
    localparam int JFL_DIV_W = 7;
    localparam int JFL_DIVISOR_W = 6;
    localparam int JFL_PRESCALE_BIT = 6;
    localparam int JFL_ERASE_CNT_W = 16;
    localparam int JFL_PRE_CNT_W = 4;

    // instruction codes
    localparam logic [JFL_IR_W-1:0] JFL_INS_UNLOCK_DEF = 4'h8;
    localparam logic [JFL_IR_W-1:0] JFL_INS_BYPASS = 4'hF;
    localparam logic [JFL_IR_W-1:0] JFL_IR_CAPTURE = 4'h1;

    // clocking of the flash timing path
    localparam int JFL_CORE_CLOCK_FREQ_HZ = 25_000_000;
    localparam int JFL_FLASH_IN_DIV = 2;
    localparam int JFL_PRESCALE_FACTOR = 8;
    localparam int JFL_PRESCALE_THRESH_HZ = 12_800_000;
    localparam int JFL_FCLK_MIN_HZ = 150_000;
    localparam int JFL_FCLK_MAX_HZ = 200_000;
    localparam logic [JFL_PRE_CNT_W-1:0] JFL_PRE_LIM_PLAIN =
        4'(JFL_FLASH_IN_DIV - 1);
    localparam logic [JFL_PRE_CNT_W-1:0] JFL_PRE_LIM_DIV8 =
        4'(JFL_FLASH_IN_DIV * JFL_PRESCALE_FACTOR - 1);
    localparam int JFL_ERASE_TICKS_DEF = 20;

    typedef enum logic [3:0] {
        JFL_TAP_RESET  = 4'h0,
        JFL_TAP_IDLE   = 4'h1,
        JFL_TAP_SEL_DR = 4'h3,
        JFL_TAP_CAP_DR = 4'h2,
        JFL_TAP_SH_DR  = 4'h6,
        JFL_TAP_EX1_DR = 4'h7,
        JFL_TAP_PA_DR  = 4'h5,
        JFL_TAP_EX2_DR = 4'h4,
        JFL_TAP_UPD_DR = 4'hC,
        JFL_TAP_SEL_IR = 4'hD,
        JFL_TAP_CAP_IR = 4'hF,
        JFL_TAP_SH_IR  = 4'hE,
        JFL_TAP_EX1_IR = 4'hA,
        JFL_TAP_PA_IR  = 4'hB,
        JFL_TAP_EX2_IR = 4'h9,
        JFL_TAP_UPD_IR = 4'h8
    } jfl_tap_t;

    typedef struct packed {
        logic prescale_by_eight;
        logic [JFL_DIVISOR_W-1:0] divisor;
    } jfl_div_t;

    localparam jfl_div_t JFL_DIV_RST = 7'h00;

    typedef struct packed {
        jfl_tap_t tap;
        logic tck_q;
        logic [JFL_IR_W-1:0] ir;
        logic [JFL_IR_W-1:0] ir_sh;
        logic [JFL_DIV_W-1:0] dr_sh;
        logic byp;
        jfl_div_t jtag_div;
        logic div_loaded;
        logic tdo;
        logic tdo_oe_n;
        jfl_div_t eff_div;
        logic [JFL_PRE_CNT_W-1:0] pre_cnt;
        logic [JFL_DIVISOR_W-1:0] div_cnt;
        logic tick;
        logic busy;
        logic done;
        logic [JFL_ERASE_CNT_W-1:0] erase_cnt;
        logic cap_pending;
        logic read_disable;
        logic backdoor;
    } jfl_state_t;
endpackage : jfl_pkg
